/* logic/tmcfg_pkg.sv */
`default_nettype none
package tmcfg_pkg;
	localparam logic [7:0] TMCFG_ADDR_CFG = 8'h40;
	localparam logic [7:0] TMCFG_ADDR_STATUS = 8'h41;
	localparam logic [7:0] TMCFG_ADDR_MASK = 8'h43;
	localparam logic [7:0] TMCFG_ADDR_MIRROR = 8'h4C;
	localparam logic [7:0] TMCFG_ADDR_TRIP_LOCAL = 8'h13;
	localparam logic [7:0] TMCFG_ADDR_TRIP_REMOTE = 8'h14;
	localparam logic [7:0] TMCFG_ADDR_DEF_LOCAL = 8'h17;
	localparam logic [7:0] TMCFG_ADDR_DEF_REMOTE = 8'h18;
	localparam int TMCFG_BIT_RUN = 0;
	localparam int TMCFG_BIT_IRQ_EN = 1;
	localparam int TMCFG_BIT_IRQ_CLR = 2;
	localparam int TMCFG_BIT_LOCK = 3;
	localparam int TMCFG_BIT_SOFT_RST = 4;
	localparam int TMCFG_BIT_FAN_FLOAT = 5;
	localparam int TMCFG_BIT_POL_FLIP = 6;
	localparam int TMCFG_BIT_DIODE2 = 7;
	localparam int TMCFG_STS_GPI = 4;
	localparam int TMCFG_STS_OVERTEMP = 6;
	localparam logic [7:0] TMCFG_CFG_RESET = 8'h25;
	localparam logic [7:0] TMCFG_STATUS_RESET = 8'h00;
	localparam logic [7:0] TMCFG_MASK_RESET = 8'h00;
	localparam logic [7:0] TMCFG_MASK_WMASK = 8'hF0;
	localparam logic [7:0] TMCFG_TRIP_LOCAL_RESET = 8'h46;
	localparam logic [7:0] TMCFG_TRIP_REMOTE_RESET = 8'h64;
endpackage : tmcfg_pkg
`default_nettype wire

/* logic/tmcfg_regs.sv */
`timescale 1ns/100ps
`default_nettype none
module tmcfg_regs (
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic secondary_reset_in,
	input wire logic wr_en,
	input wire logic rd_en,
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	output logic [7:0] rdata,
	input wire logic [7:0] status_events,
	input wire logic overtemp_line_n,
	input wire logic general_input_pin,
	output logic run_en,
	output logic int_n,
	output logic fan_off_o,
	output logic fan_off_oe,
	output logic second_diode_select,
	output logic overtemp_out_oe,
	output logic trip_default_active,
	output logic [7:0] trip_local,
	output logic [7:0] trip_remote
);
	import tmcfg_pkg::*;

	logic [7:0] cfg_q;
	logic [7:0] status_q;
	logic [7:0] mask_q;
	logic [7:0] trip_local_q;
	logic [7:0] trip_remote_q;
	logic lock_wr_done_q;
	logic secondary_reset_in_q;
	logic otemp_q;
	logic gpi_level;
	logic soft_rst;
	logic cfg_wr;
	logic [7:0] live_events;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] ref_a);
		hit = (a == ref_a);
	endfunction : hit

	assign cfg_wr = wr_en && hit(addr, TMCFG_ADDR_CFG);
	assign soft_rst = cfg_wr && wdata[TMCFG_BIT_SOFT_RST];
	// general input shares a pin with diode 2; ignored while that is chosen
	assign gpi_level = second_diode_select ? 1'b0
		: (general_input_pin ^ cfg_q[TMCFG_BIT_POL_FLIP]);

	always_comb begin
		live_events = status_events;
		live_events[TMCFG_STS_GPI] = gpi_level;
		live_events[TMCFG_STS_OVERTEMP] = ~overtemp_line_n;
	end

	// secondary reset taken as synchronous; re-arms the write-once lock
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			secondary_reset_in_q <= 1'b0;
		end else begin
			secondary_reset_in_q <= secondary_reset_in;
		end
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			otemp_q <= 1'b0;
		end else begin
			otemp_q <= ~overtemp_line_n;
		end
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			cfg_q <= TMCFG_CFG_RESET;
		end else if (secondary_reset_in_q || soft_rst) begin
			cfg_q <= TMCFG_CFG_RESET;
		end else begin
			if (cfg_wr) begin
				cfg_q[TMCFG_BIT_RUN] <= wdata[TMCFG_BIT_RUN];
				cfg_q[TMCFG_BIT_IRQ_EN] <= wdata[TMCFG_BIT_IRQ_EN];
				cfg_q[TMCFG_BIT_IRQ_CLR] <= wdata[TMCFG_BIT_IRQ_CLR];
				cfg_q[TMCFG_BIT_FAN_FLOAT] <= wdata[TMCFG_BIT_FAN_FLOAT];
				cfg_q[TMCFG_BIT_POL_FLIP] <= wdata[TMCFG_BIT_POL_FLIP];
				cfg_q[TMCFG_BIT_DIODE2] <= wdata[TMCFG_BIT_DIODE2];
				if (!lock_wr_done_q) begin
					cfg_q[TMCFG_BIT_LOCK] <= wdata[TMCFG_BIT_LOCK];
				end
			end
			// overtemp wins over any software write of the same cycle
			if (otemp_q) begin
				cfg_q[TMCFG_BIT_FAN_FLOAT] <= 1'b1;
			end
			cfg_q[TMCFG_BIT_SOFT_RST] <= 1'b0;
		end
	end

	// write-once: the lock's write history survives soft reset, the lock bit does not
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			lock_wr_done_q <= 1'b0;
		end else if (secondary_reset_in_q) begin
			lock_wr_done_q <= 1'b0;
		end else if (cfg_wr) begin
			lock_wr_done_q <= 1'b1;
		end
	end

	// status bits are sticky except general input, which tracks the pin
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			status_q <= TMCFG_STATUS_RESET;
		end else if (secondary_reset_in_q || soft_rst) begin
			status_q <= TMCFG_STATUS_RESET;
		end else begin
			if (cfg_q[TMCFG_BIT_RUN]) begin
				status_q <= status_q | live_events;
			end
			status_q[TMCFG_STS_GPI] <= gpi_level;
		end
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			mask_q <= TMCFG_MASK_RESET;
		end else if (secondary_reset_in_q || soft_rst) begin
			mask_q <= TMCFG_MASK_RESET;
		end else if (wr_en && hit(addr, TMCFG_ADDR_MASK)) begin
			mask_q <= wdata & TMCFG_MASK_WMASK;
		end
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			trip_local_q <= TMCFG_TRIP_LOCAL_RESET;
			trip_remote_q <= TMCFG_TRIP_REMOTE_RESET;
		end else if (wr_en && !cfg_q[TMCFG_BIT_LOCK]) begin
			if (hit(addr, TMCFG_ADDR_TRIP_LOCAL)) begin
				trip_local_q <= wdata;
			end
			if (hit(addr, TMCFG_ADDR_TRIP_REMOTE)) begin
				trip_remote_q <= wdata;
			end
		end
	end

	// interrupt line: status is not cleared by run going low
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			int_n <= 1'b1;
		end else begin
			int_n <= !(cfg_q[TMCFG_BIT_IRQ_EN] && !cfg_q[TMCFG_BIT_IRQ_CLR]
				&& |(status_q & ~mask_q));
		end
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			rdata <= 8'h00;
		end else if (rd_en) begin
			case (addr)
				TMCFG_ADDR_CFG: rdata <= cfg_q;
				TMCFG_ADDR_STATUS: rdata <= status_q;
				TMCFG_ADDR_MIRROR: rdata <= status_q;
				TMCFG_ADDR_MASK: rdata <= mask_q;
				TMCFG_ADDR_TRIP_LOCAL: rdata <= trip_local_q;
				TMCFG_ADDR_TRIP_REMOTE: rdata <= trip_remote_q;
				TMCFG_ADDR_DEF_LOCAL: rdata <= TMCFG_TRIP_LOCAL_RESET;
				TMCFG_ADDR_DEF_REMOTE: rdata <= TMCFG_TRIP_REMOTE_RESET;
				default: rdata <= 8'h00;
			endcase
		end
	end

	assign run_en = cfg_q[TMCFG_BIT_RUN];
	assign fan_off_o = 1'b0;
	// read-back bit 5 shows the inverse of this enable, the driver, not the external net
	assign fan_off_oe = ~cfg_q[TMCFG_BIT_FAN_FLOAT];
	assign second_diode_select = cfg_q[TMCFG_BIT_DIODE2];
	assign overtemp_out_oe = ~cfg_q[TMCFG_BIT_DIODE2];
	assign trip_default_active = ~cfg_q[TMCFG_BIT_LOCK];
	assign trip_local = trip_local_q;
	assign trip_remote = trip_remote_q;
endmodule : tmcfg_regs
`default_nettype wire

/* verif/tmcfg_regs_chk.sv */
`timescale 1ns/100ps
`default_nettype none
module tmcfg_regs_chk
	import tmcfg_pkg::*;
(
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic secondary_reset_in,
	input wire logic wr_en,
	input wire logic rd_en,
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic [7:0] rdata,
	input wire logic overtemp_line_n,
	input wire logic run_en,
	input wire logic int_n,
	input wire logic fan_off_oe,
	input wire logic second_diode_select,
	input wire logic overtemp_out_oe,
	input wire logic trip_default_active,
	input wire logic [7:0] trip_local
);
	logic cw;
	logic secondary_reset_in_seen;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!nrst);
	// secondary reset acts one cycle late, so track it here
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			secondary_reset_in_seen <= 1'b0;
		end else begin
			secondary_reset_in_seen <= secondary_reset_in;
		end
	end
	// soft and secondary reset win over a plain write
	assign cw = wr_en && addr == TMCFG_ADDR_CFG && !wdata[4]
		&& !secondary_reset_in && !secondary_reset_in_seen;
	property p_run; cw |=> run_en == $past(wdata[0]); endproperty
	a_run: assert property (p_run) else $error("run_en wrong");
	property p_dio;
		cw |=> second_diode_select == $past(wdata[7])
			&& overtemp_out_oe != $past(wdata[7]);
	endproperty
	a_dio: assert property (p_dio) else $error("pin share wrong");
	property p_fan;
		cw && overtemp_line_n && $past(overtemp_line_n)
			|=> fan_off_oe != $past(wdata[5]);
	endproperty
	a_fan: assert property (p_fan) else $error("fan pin wrong");
	property p_ovt; !overtemp_line_n |=> ##1 !fan_off_oe; endproperty
	a_ovt: assert property (p_ovt) else $error("fan not forced");
	property p_int; cw && (wdata[2] || !wdata[1]) |-> ##2 int_n; endproperty
	a_int: assert property (p_int) else $error("int_n low");
	property p_lock; cw && !trip_default_active |=> !trip_default_active;
	endproperty
	a_lock: assert property (p_lock) else $error("lock lost");
	property p_trip;
		wr_en && addr == TMCFG_ADDR_TRIP_LOCAL && !trip_default_active
			|=> $stable(trip_local);
	endproperty
	a_trip: assert property (p_trip) else $error("trip moved");
	property p_rd;
		rd_en && addr == TMCFG_ADDR_CFG
			|=> !rdata[4] && rdata[5] != $past(fan_off_oe);
	endproperty
	a_rd: assert property (p_rd) else $error("cfg readback wrong");
	c_lock: cover property (cw && wdata[3] ##1 !trip_default_active);
	c_int: cover property ($fell(int_n));
	c_ovt: cover property (!overtemp_line_n ##2 !fan_off_oe);
endmodule : tmcfg_regs_chk
bind tmcfg_regs tmcfg_regs_chk i_chk (.*);
`default_nettype wire

/* verif/tmcfg_regs_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module tmcfg_regs_tb import tmcfg_pkg::*;;
	logic core_clk, nrst, secondary_reset_in, wr_en, rd_en, int_n;
	logic overtemp_line_n, general_input_pin, run_en, fan_off_o, fan_off_oe;
	logic second_diode_select, overtemp_out_oe, trip_default_active;
	logic [7:0] addr, wdata, rdata, status_events, trip_local, trip_remote;
	int n_errors, check_count;
	tmcfg_regs i_dut (.*);
	task chk(input logic [7:0] g, e);
		check_count++;
		if (g !== e) begin
			n_errors++;
			$display("Error t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk
	task wr(input logic [7:0] a, d);
		wr_en <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge core_clk);
		wr_en <= 1'b0;
		@(posedge core_clk);
	endtask : wr
	task rd(input logic [7:0] a, e);
		rd_en <= 1'b1;
		addr <= a;
		@(posedge core_clk);
		rd_en <= 1'b0;
		@(posedge core_clk);
		chk(rdata, e);
	endtask : rd
	task sr;
		secondary_reset_in <= 1'b1;
		@(posedge core_clk);
		secondary_reset_in <= 1'b0;
		repeat (2) @(posedge core_clk);
	endtask : sr
	task end_sim;
		$display("errors=%0d checks=%0d", n_errors, check_count);
		if (n_errors == 0 && check_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : end_sim
	initial begin
		core_clk = 1'b0;
		forever #25 core_clk = ~core_clk;
	end
	// hang guard, far beyond the 72 or so cycles needed
	initial begin
		repeat (3000) @(posedge core_clk);
		n_errors++;
		end_sim;
	end
	initial begin
		{nrst, secondary_reset_in, wr_en, rd_en, general_input_pin} = 5'h00;
		{addr, wdata, status_events} = 24'h000000;
		overtemp_line_n = 1'b1;
		repeat (6) @(posedge core_clk);
		nrst <= 1'b1;
		rd(TMCFG_ADDR_CFG, 8'h25);
		rd(TMCFG_ADDR_STATUS, 8'h00);
		rd(8'h42, 8'h00);
		rd(TMCFG_ADDR_TRIP_REMOTE, 8'h64);
		rd(TMCFG_ADDR_DEF_LOCAL, 8'h46);
		chk(8'(fan_off_o), 8'h00);
		chk(8'({run_en, fan_off_oe, trip_default_active}), 8'h05);
		wr(TMCFG_ADDR_CFG, 8'hC2);
		chk(8'({run_en, fan_off_oe, second_diode_select}), 8'h03);
		rd(TMCFG_ADDR_CFG, 8'hC2);
		status_events <= 8'h01;
		wr(TMCFG_ADDR_CFG, 8'h03);
		rd(TMCFG_ADDR_STATUS, 8'h01);
		chk(8'(int_n), 8'h00);
		wr(TMCFG_ADDR_CFG, 8'h02);
		rd(TMCFG_ADDR_CFG, 8'h02);
		chk(8'(int_n), 8'h00);
		status_events <= 8'h00;
		wr(TMCFG_ADDR_CFG, 8'h06);
		rd(TMCFG_ADDR_STATUS, 8'h01);
		chk(8'(int_n), 8'h01);
		wr(TMCFG_ADDR_CFG, 8'h47);
		rd(TMCFG_ADDR_STATUS, 8'h11);
		overtemp_line_n <= 1'b0;
		repeat (2) @(posedge core_clk);
		overtemp_line_n <= 1'b1;
		rd(TMCFG_ADDR_CFG, 8'h67);
		wr(TMCFG_ADDR_MASK, 8'hFF);
		rd(TMCFG_ADDR_MASK, 8'hF0);
		wr(TMCFG_ADDR_CFG, 8'h10);
		rd(TMCFG_ADDR_CFG, 8'h25);
		rd(TMCFG_ADDR_STATUS, 8'h00);
		rd(TMCFG_ADDR_MIRROR, 8'h00);
		rd(TMCFG_ADDR_MASK, 8'h00);
		// lock history is only re-armed by nrst or the secondary reset
		sr;
		wr(TMCFG_ADDR_TRIP_LOCAL, 8'h50);
		chk(trip_local, 8'h50);
		wr(TMCFG_ADDR_CFG, 8'h2D);
		chk(8'(trip_default_active), 8'h00);
		wr(TMCFG_ADDR_TRIP_LOCAL, 8'h77);
		chk(trip_local, 8'h50);
		wr(TMCFG_ADDR_TRIP_REMOTE, 8'h11);
		chk(trip_remote, 8'h64);
		wr(TMCFG_ADDR_CFG, 8'h25);
		rd(TMCFG_ADDR_CFG, 8'h2D);
		sr;
		chk(8'(trip_default_active), 8'h01);
		end_sim;
	end
endmodule : tmcfg_regs_tb
`default_nettype wire
